// [logic/fcr_pkg.sv]
// Package for the fieldbus command register block
package fcr_pkg;

  // ************************************************************
  // Command word layout
  // ************************************************************
  localparam int FCR_PARAM_HI = 15;
  localparam int FCR_PARAM_LO = 8;
  localparam int FCR_CODE_HI = 7;
  localparam int FCR_CODE_LO = 0;
  localparam logic [7:0] FCR_PARAM_NONE = 8'h00;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] FCR_CMD_CLR_CNT = 8'h08;
  localparam logic [7:0] FCR_CMD_COLD = 8'hF8;
  localparam logic [7:0] FCR_CMD_WARM = 8'hF9;
  localparam logic [7:0] FCR_CMD_PASSIVE = 8'hF5;
  localparam logic [7:0] FCR_CMD_ACTIVE = 8'hF6;
  localparam logic [7:0] FCR_CMD_SWAP = 8'hF7;

  // ************************************************************
  // Addresses and timing
  // ************************************************************
  localparam logic [6:0] FCR_DEF_STATION_ADDR = 7'h7E;
  localparam logic [7:0] FCR_DEF_SERVICE_ADDR = 8'h01;
  localparam int FCR_CLK_MHZ = 250;
  localparam int FCR_LED_MS = 50;
  localparam int FCR_LED_CYCLES = FCR_LED_MS * FCR_CLK_MHZ * 1000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] param;
    logic [7:0] code;
  } fcr_cmd_t;

  typedef struct packed {
    logic cold_start;
    logic warm_restart;
    logic clr_all;
    logic clr_slot;
    logic [7:0] slot;
  } fcr_act_t;

endpackage : fcr_pkg

// [logic/fcr_command_unit.sv]
// Command word interpreter of the remote I/O communication unit
// Notes on behaviour
// - Command word is two bytes: parameter byte first, command code second.
// - A command runs once, on the first transfer carrying a changed word.
// - Global status word goes in the first two response bytes.
// - Code 0x08 with zero parameter clears every 32-bit counter.
// - Code 0x08 with nonzero parameter clears only that slot's counter.
// - Code 0xF5 makes an active unit passive; partner goes active.
// - Code 0xF6 makes a passive unit active; partner goes passive.
// - Code 0xF7 swaps active and passive roles on either unit.
// - Default station address 126 and service-bus address 1.
// - Module bus addresses follow from the own station address.
// - Indicator pulses on every active data exchange access.
`timescale 1ns/1ps

module fcr_command_unit
  import fcr_pkg::*;
#(
  parameter int SLOTS = 64,
  parameter int LED_CYCLES = FCR_LED_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Cyclic request from the bus engine
  input wire logic req_valid,
  input wire fcr_cmd_t host_command_word,
  // Cyclic response
  input wire logic [15:0] global_status,
  output logic [15:0] resp_head,
  // Redundancy link with partner unit
  input wire logic partner_go_active,
  input wire logic partner_go_passive,
  output logic unit_active,
  output logic tell_partner_active,
  output logic tell_partner_passive,
  // Actions
  output fcr_act_t action,
  output logic [SLOTS-1:0] cnt_clear,
  // Addressing
  input wire logic addr_load,
  input wire logic [6:0] addr_value,
  output logic [6:0] station_addr,
  output logic [7:0] service_addr,
  output logic [7:0] module_base,
  // Indicator
  output logic comm_led
);

  // ************************************************************
  // Input synchroniser for partner signals
  // ************************************************************
  logic [1:0] pa_sync_reg;
  logic [1:0] pp_sync_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_sync_reg <= 2'h0;
      pp_sync_reg <= 2'h0;
    end else begin
      pa_sync_reg <= {pa_sync_reg[0], partner_go_active};
      pp_sync_reg <= {pp_sync_reg[0], partner_go_passive};
    end
  end
  logic pa_d_reg;
  logic pp_d_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_d_reg <= 1'b0;
      pp_d_reg <= 1'b0;
    end else begin
      pa_d_reg <= pa_sync_reg[1];
      pp_d_reg <= pp_sync_reg[1];
    end
  end
  wire partner_act_ev = pa_sync_reg[1] & ~pa_d_reg;
  wire partner_pas_ev = pp_sync_reg[1] & ~pp_d_reg;

  // ************************************************************
  // Change detection
  // ************************************************************
  fcr_cmd_t last_reg;
  logic seen_reg;
  wire changed = req_valid && (!seen_reg || host_command_word != last_reg);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_reg <= '0;
      seen_reg <= 1'b0;
    end else if (req_valid) begin
      last_reg <= host_command_word;
      seen_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Decode
  // ************************************************************
  wire [7:0] p = host_command_word.param;
  wire [7:0] c = host_command_word.code;
  wire zero_p = (p == FCR_PARAM_NONE);
  wire do_clr_all = changed && c == FCR_CMD_CLR_CNT && zero_p;
  wire do_clr_slot = changed && c == FCR_CMD_CLR_CNT && !zero_p;
  wire do_cold = changed && zero_p && c == FCR_CMD_COLD;
  wire do_warm = changed && zero_p && c == FCR_CMD_WARM;
  wire do_pas = changed && zero_p && c == FCR_CMD_PASSIVE && unit_active;
  wire do_act = changed && zero_p && c == FCR_CMD_ACTIVE && !unit_active;
  wire do_swap = changed && zero_p && c == FCR_CMD_SWAP;
  wire partner_ev = partner_act_ev || partner_pas_ev;
  wire go_passive = partner_act_ev || (!partner_ev && (do_pas || (do_swap && unit_active)));
  wire go_active = partner_pas_ev || (!partner_ev && (do_act || (do_swap && !unit_active)));

  fcr_act_t action_next;
  always_comb begin
    action_next = '0;
    action_next.cold_start = do_cold;
    action_next.warm_restart = do_warm;
    action_next.clr_all = do_clr_all;
    action_next.clr_slot = do_clr_slot;
    action_next.slot = do_clr_slot ? p : 8'h00;
  end

  logic [SLOTS-1:0] cnt_clear_next;
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_clr
      assign cnt_clear_next[gi] = do_clr_all || (do_clr_slot && p == 8'(gi));
    end
  endgenerate

  // ************************************************************
  // Actions and redundancy role
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      action <= '0;
      cnt_clear <= '0;
      unit_active <= 1'b0;
      tell_partner_active <= 1'b0;
      tell_partner_passive <= 1'b0;
    end else begin
      action <= action_next;
      cnt_clear <= cnt_clear_next;
      tell_partner_active <= go_passive && unit_active && !partner_ev;
      tell_partner_passive <= go_active && !unit_active && !partner_ev;
      if (go_passive && unit_active) begin
        unit_active <= 1'b0;
      end else if (go_active && !unit_active) begin
        unit_active <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Response head, addressing, indicator
  // ************************************************************
  logic [31:0] led_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_head <= 16'h0000;
      station_addr <= FCR_DEF_STATION_ADDR;
      service_addr <= FCR_DEF_SERVICE_ADDR;
      module_base <= 8'h00;
      led_cnt_reg <= 32'h0;
      comm_led <= 1'b0;
    end else begin
      resp_head <= global_status;
      if (addr_load) begin
        station_addr <= addr_value;
      end
      module_base <= {1'b0, station_addr} + 8'h01;
      if (req_valid) begin
        led_cnt_reg <= 32'(LED_CYCLES);
      end else if (led_cnt_reg != 32'h0) begin
        led_cnt_reg <= led_cnt_reg - 32'h1;
      end
      comm_led <= req_valid || led_cnt_reg > 32'h1;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  once_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    req_valid && seen_reg && host_command_word == last_reg |=> action == '0)
    else $error("command repeated without change");
  clear_all_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    changed && c == FCR_CMD_CLR_CNT && zero_p |=> &cnt_clear)
    else $error("clear all missed");
  clear_slot_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    do_clr_slot |=> action.clr_slot && !action.clr_all && action.slot == $past(p))
    else $error("slot clear wrong");
  restart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    changed && zero_p && c == FCR_CMD_COLD |=> action.cold_start && !action.warm_restart)
    else $error("cold start missed");
  passive_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    unit_active && changed && zero_p && c == FCR_CMD_PASSIVE && !partner_ev
    |=> !unit_active && tell_partner_active)
    else $error("become passive failed");
  active_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !unit_active && changed && zero_p && c == FCR_CMD_ACTIVE && !partner_ev
    |=> unit_active && tell_partner_passive)
    else $error("become active failed");
  swap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    do_swap && !partner_act_ev && !partner_pas_ev |=> unit_active != $past(unit_active))
    else $error("swap failed");
  status_head_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> resp_head == $past(global_status))
    else $error("status head stale");
  led_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    req_valid |=> comm_led [*2])
    else $error("indicator not lit");
  partner_take_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    partner_act_ev && !partner_pas_ev |=> !unit_active && !tell_partner_passive)
    else $error("partner take over missed");
  partner_give_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    partner_pas_ev && !partner_act_ev |=> unit_active && !tell_partner_active)
    else $error("partner give up missed");
  module_base_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    addr_load |=> station_addr == $past(addr_value) ##1 module_base == {1'b0, $past(addr_value, 2)} + 8'h01)
    else $error("module base not following station address");

endmodule : fcr_command_unit

// [tb/fcr_partner_model.sv]
// Redundancy partner unit model
`timescale 1ns/1ps
module fcr_partner_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Link from unit under test
  input wire logic tell_partner_active,
  input wire logic tell_partner_passive,
  // Bench requests and link to unit
  input wire logic take_over,
  input wire logic give_up,
  output logic partner_go_active,
  output logic partner_go_passive,
  output logic partner_role
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      partner_role <= 1'b1;
      partner_go_active <= 1'b0;
      partner_go_passive <= 1'b0;
    end else begin
      partner_go_active <= take_over;
      partner_go_passive <= give_up;
      if (take_over || tell_partner_active) begin
        partner_role <= 1'b1;
      end else if (give_up || tell_partner_passive) begin
        partner_role <= 1'b0;
      end
    end
  end
endmodule : fcr_partner_model

// [tb/testbench.sv]
// Self-checking bench for the command unit
`timescale 1ns/1ps
module testbench;
  import fcr_pkg::*;
  logic core_clk, rst_b, req_valid, addr_load, take_over, give_up;
  fcr_cmd_t word;
  logic [15:0] global_status, resp_head;
  logic [6:0] addr_value, station_addr;
  logic [7:0] service_addr, module_base;
  logic unit_active, tpa, tpp, pga, pgp, p_role, comm_led;
  fcr_act_t action;
  logic [63:0] cnt_clear;
  int num_errors = 0;
  int n_checks = 0;
  fcr_command_unit #(.SLOTS(64), .LED_CYCLES(8)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .req_valid(req_valid), .host_command_word(word), .global_status(global_status),
    .resp_head(resp_head), .partner_go_active(pga), .partner_go_passive(pgp),
    .unit_active(unit_active), .tell_partner_active(tpa), .tell_partner_passive(tpp),
    .action(action), .cnt_clear(cnt_clear), .addr_load(addr_load), .addr_value(addr_value),
    .station_addr(station_addr), .service_addr(service_addr), .module_base(module_base),
    .comm_led(comm_led));
  fcr_partner_model peer (.core_clk(core_clk), .rst_b(rst_b), .tell_partner_active(tpa),
    .tell_partner_passive(tpp), .take_over(take_over), .give_up(give_up),
    .partner_go_active(pga), .partner_go_passive(pgp), .partner_role(p_role));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [15:0] w);
    @(negedge core_clk);
    req_valid = 1'b1;
    word = w;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask : send
  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_clear;
    send(16'h0008);
    chk(action, 12'h200);
    chk(cnt_clear, '1);
    send(16'h0008);
    chk(action, 12'h000);
    send(16'h2A08);
    chk(action, 12'h12A);
    chk(cnt_clear, 64'h1 << 42);
    $display("test clear done");
  endtask : t_clear
  task automatic t_restart;
    send(16'h00F8);
    chk(action, 12'h800);
    send(16'h00F9);
    chk(action, 12'h400);
    send(16'h01F8);
    chk(action, 12'h000);
    $display("test restart done");
  endtask : t_restart
  task automatic t_roles;
    logic [15:0] w [8] = '{16'h00F5, 16'h00F6, 16'h00F7, 16'h00F7, 16'h00F6, 16'h0000,
      16'h00F6, 16'h00F5};
    logic [2:0] e [8] = '{3'b000, 3'b101, 3'b010, 3'b000, 3'b101, 3'b100, 3'b100, 3'b010};
    for (int i = 0; i < 8; i++) begin
      send(w[i]);
      chk({unit_active, tpa, tpp}, e[i]);
    end
    @(negedge core_clk);
    chk({p_role, unit_active}, 2'b10);
    send(16'h00F6);
    take_over = 1'b1;
    repeat (6) @(negedge core_clk);
    chk({p_role, unit_active}, 2'b10);
    take_over = 1'b0;
    give_up = 1'b1;
    repeat (6) @(negedge core_clk);
    chk({p_role, unit_active}, 2'b01);
    give_up = 1'b0;
    send(16'h00F5);
    chk({unit_active, tpa, tpp}, 3'b010);
    take_over = 1'b1;
    repeat (2) @(negedge core_clk);
    send(16'h00F6);
    chk({unit_active, tpa, tpp}, 3'b000);
    take_over = 1'b0;
    $display("test roles done");
  endtask : t_roles
  task automatic t_misc;
    chk({station_addr, service_addr}, {7'h7E, 8'h01});
    global_status = 16'hA784;
    send(16'h1208);
    chk(resp_head, 16'hA784);
    chk(comm_led, 1'b1);
    repeat (12) @(negedge core_clk);
    chk(comm_led, 1'b0);
    addr_load = 1'b1;
    addr_value = 7'h10;
    @(negedge core_clk);
    addr_load = 1'b0;
    @(negedge core_clk);
    chk({station_addr, module_base}, {7'h10, 8'h11});
    $display("test misc done");
  endtask : t_misc
  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    {req_valid, addr_load, take_over, give_up} = 4'h0;
    word = 16'h0000;
    global_status = 16'h0000;
    addr_value = 7'h00;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    chk(unit_active, 1'b0);
    t_misc();
    t_clear();
    t_restart();
    t_roles();
    finish_test();
  end
endmodule : testbench
